// >>> hw/ptu_top.sv
// Overview of operation
// - each port bit drives when its direction bit is one (port B pins 6 and 7 also when port-output enable is set), else input
// - port data reads return the synchronised pin levels for all bits
// - any port B data register access pulses the handshake strobe low for one cycle
// - a falling edge on the flag pin sets the flag status bit
// - each timer has a readable down counter and a write-only latch
// - start bit runs or halts the counter, which holds while stopped
// - port-output enable puts timer A on pin 6, timer B on pin 7
// - toggle select chooses toggle output or one-cycle underflow pulse
// - toggle output goes high on start and low on reset
// - one-shot mode reloads on underflow and clears start in the same cycle
// - continuous mode reloads on underflow and keeps counting
// - force-load strobe copies latch into counter, stores nothing
// - timer A counts system cycles or count pin rising edges
// - timer B counts clock, count pin, A underflows, or gated A underflows
// - counter reloads on underflow, force load, or stopped high-byte write
// - high-byte write while running changes only the latch
// - clock keeps BCD tenths, seconds, minutes, 12-hour hours with pm bit
// - clock advances from the mains pin at 60 or 50 Hz
// - alarm shares clock offsets, write-only, selected; match sets status
// - hours write halts the clock until tenths is written
// - hours read freezes read copies until tenths is read
// - reset clears ports, direction and control, latches go all ones
// - timer A control bit 7 selects 50 Hz when one, 60 Hz when zero
module ptu_top
	import ptu_pkg::*;
(
	input  wire logic       I_CLK_SYS,
	input  wire logic       I_RST,
	input  wire logic       I_CS_N,
	input  wire logic       I_RW,
	input  wire logic [3:0] I_RS,
	input  wire logic [7:0] I_DB,
	output logic [7:0]      O_DB,
	output logic            O_DB_OE,
	input  wire logic [7:0] I_PA,
	output logic [7:0]      O_PA,
	output logic [7:0]      O_PA_OE,
	input  wire logic [7:0] I_PB,
	output logic [7:0]      O_PB,
	output logic [7:0]      O_PB_OE,
	output logic            O_HANDSHAKE_STROBE_N,
	input  wire logic       I_FLAG_N,
	input  wire logic       I_COUNT_PIN,
	input  wire logic       I_TOD_PIN
);
	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic        cs_prev_r;
	logic        access;
	logic        rd_acc;
	logic        wr_acc;
	logic [REG_COUNT-1:0] rd_sel;
	logic [REG_COUNT-1:0] wr_sel;
	logic [7:0]  rd_word [REG_COUNT];
	logic [7:0]  pa_meta_r;
	logic [7:0]  pa_sync_r;
	logic [7:0]  pb_meta_r;
	logic [7:0]  pb_sync_r;
	logic [7:0]  pra_r;
	logic [7:0]  prb_r;
	logic [7:0]  port_a_direction_r;
	logic [7:0]  port_b_direction_r;
	logic [7:0]  cra_r;
	logic [7:0]  cra_nxt;
	logic [7:0]  crb_r;
	logic [7:0]  crb_nxt;
	logic [7:0]  evt_r;
	logic [7:0]  evt_set;
	logic [7:0]  pb_out_nxt;
	logic [7:0]  pb_oe_nxt;
	logic        flag_fall;
	logic        cnt_level;
	logic        cnt_rise;
	logic        tod_rise;
	logic        ta_en;
	logic        tb_en;
	logic        ta_uf;
	logic        tb_uf;
	logic        ta_out;
	logic        tb_out;
	logic [15:0] ta_count;
	logic [15:0] tb_count;
	logic        ta_start_rise;
	logic        tb_start_rise;
	logic [3:0]  tenths_r;
	logic [6:0]  sec_r;
	logic [6:0]  min_r;
	logic [4:0]  hr_r;
	logic        pm_r;
	logic [3:0]  alm_tenths_r;
	logic [6:0]  alm_sec_r;
	logic [6:0]  alm_min_r;
	logic [4:0]  alm_hr_r;
	logic        alm_pm_r;
	logic [7:0]  snap_r [4];
	logic        frozen_r;
	logic        run_r;
	logic [2:0]  div_r;
	logic [2:0]  div_last;
	logic        tenth_tick;
	logic        ten_wrap;
	logic        sec_wrap;
	logic        min_wrap;
	logic        wr_time;
	logic        wr_alarm;
	logic        match_now;
	logic        match_prev_r;
	logic [7:0]  live_word [4];

	////////////////////////////////////////////////////////////////////////////////
	// bcd increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [3:0] hi;
		hi = v[7:4] + 4'h1;
		bcd_inc = (v[3:0] == TENTH_LAST) ? {hi, 4'h0} : v + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus access decode, one access per select assertion
	assign access = ~I_CS_N & cs_prev_r;
	assign rd_acc = access & I_RW;
	assign wr_acc = access & ~I_RW;

	generate
		for (genvar g = 0; g < REG_COUNT; g++) begin : g_sel
			assign rd_sel[g] = rd_acc & (I_RS == 4'(g));
			assign wr_sel[g] = wr_acc & (I_RS == 4'(g));
		end
	endgenerate

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			cs_prev_r <= 1'b1;
			O_DB      <= REG_RESET;
			O_DB_OE   <= 1'b0;
		end else begin
			cs_prev_r <= I_CS_N;
			O_DB      <= rd_word[I_RS];
			O_DB_OE   <= ~I_CS_N & I_RW;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			pa_meta_r <= REG_RESET;
			pa_sync_r <= REG_RESET;
			pb_meta_r <= REG_RESET;
			pb_sync_r <= REG_RESET;
		end else begin
			pa_meta_r <= I_PA;
			pa_sync_r <= pa_meta_r;
			pb_meta_r <= I_PB;
			pb_sync_r <= pb_meta_r;
		end
	end

	ptu_pin_sync u_flag (
		.i_clk   (I_CLK_SYS),
		.i_rst   (I_RST),
		.i_pin   (I_FLAG_N),
		.o_level (),
		.o_rise  (),
		.o_fall  (flag_fall)
	);

	ptu_pin_sync u_count (
		.i_clk   (I_CLK_SYS),
		.i_rst   (I_RST),
		.i_pin   (I_COUNT_PIN),
		.o_level (cnt_level),
		.o_rise  (cnt_rise),
		.o_fall  ()
	);

	ptu_pin_sync u_mains (
		.i_clk   (I_CLK_SYS),
		.i_rst   (I_RST),
		.i_pin   (I_TOD_PIN),
		.o_level (),
		.o_rise  (tod_rise),
		.o_fall  ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// ports, direction and handshake strobe
	assign pb_out_nxt = {crb_r[CTL_PORT_EN] ? tb_out : prb_r[PB_TIMER_B_BIT],
		cra_r[CTL_PORT_EN] ? ta_out : prb_r[PB_TIMER_A_BIT], prb_r[5:0]};
	assign pb_oe_nxt  = {port_b_direction_r[PB_TIMER_B_BIT] | crb_r[CTL_PORT_EN],
		port_b_direction_r[PB_TIMER_A_BIT] | cra_r[CTL_PORT_EN], port_b_direction_r[5:0]};

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			pra_r                <= REG_RESET;
			prb_r                <= REG_RESET;
			port_a_direction_r               <= REG_RESET;
			port_b_direction_r               <= REG_RESET;
			O_PA                 <= REG_RESET;
			O_PA_OE              <= REG_RESET;
			O_PB                 <= REG_RESET;
			O_PB_OE              <= REG_RESET;
			O_HANDSHAKE_STROBE_N <= 1'b1;
		end else begin
			if (wr_sel[REG_PORT_A_DATA]) pra_r <= I_DB;
			if (wr_sel[REG_PORT_B_DATA]) prb_r <= I_DB;
			if (wr_sel[REG_PORT_A_DIR]) port_a_direction_r <= I_DB;
			if (wr_sel[REG_PORT_B_DIR]) port_b_direction_r <= I_DB;
			O_PA                 <= pra_r;
			O_PA_OE              <= port_a_direction_r;
			O_PB                 <= pb_out_nxt;
			O_PB_OE              <= pb_oe_nxt;
			O_HANDSHAKE_STROBE_N <= ~(rd_sel[REG_PORT_B_DATA] |
				wr_sel[REG_PORT_B_DATA]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timer control registers, load bit never stored
	assign ta_start_rise = wr_sel[REG_TIMER_A_CTRL] & I_DB[CTL_START] & ~cra_r[CTL_START];
	assign tb_start_rise = wr_sel[REG_TIMER_B_CTRL] & I_DB[CTL_START] & ~crb_r[CTL_START];

	always_comb begin
		cra_nxt = cra_r;
		if (ta_uf & cra_r[CTL_ONE_SHOT]) cra_nxt[CTL_START] = 1'b0;
		if (wr_sel[REG_TIMER_A_CTRL]) cra_nxt = I_DB;
		cra_nxt[CTL_LOAD] = 1'b0;
	end

	always_comb begin
		crb_nxt = crb_r;
		if (tb_uf & crb_r[CTL_ONE_SHOT]) crb_nxt[CTL_START] = 1'b0;
		if (wr_sel[REG_TIMER_B_CTRL]) crb_nxt = I_DB;
		crb_nxt[CTL_LOAD] = 1'b0;
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			cra_r <= REG_RESET;
			crb_r <= REG_RESET;
		end else begin
			cra_r <= cra_nxt;
			crb_r <= crb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// count sources and the two timers
	assign ta_en = cra_r[CTL_INMODE] ? cnt_rise : 1'b1;
	assign tb_en = (crb_r[CTL_INMODE_HI:CTL_INMODE] == SRC_SYS_CLOCK) ? 1'b1 :
		(crb_r[CTL_INMODE_HI:CTL_INMODE] == SRC_COUNT_PIN) ? cnt_rise :
		(crb_r[CTL_INMODE_HI:CTL_INMODE] == SRC_A_UNDER) ? ta_uf :
		(ta_uf & cnt_level);

	ptu_timer u_timer_a (
		.i_clk        (I_CLK_SYS),
		.i_rst        (I_RST),
		.i_count_en   (ta_en),
		.i_start      (cra_r[CTL_START]),
		.i_start_rise (ta_start_rise),
		.i_toggle_sel (cra_r[CTL_TOGGLE]),
		.i_force_load (wr_sel[REG_TIMER_A_CTRL] & I_DB[CTL_LOAD]),
		.i_lat_lo_wr  (wr_sel[REG_TIMER_A_LO]),
		.i_lat_hi_wr  (wr_sel[REG_TIMER_A_HI]),
		.i_wdata      (I_DB),
		.o_count      (ta_count),
		.o_underflow  (ta_uf),
		.o_port_out   (ta_out)
	);

	ptu_timer u_timer_b (
		.i_clk        (I_CLK_SYS),
		.i_rst        (I_RST),
		.i_count_en   (tb_en),
		.i_start      (crb_r[CTL_START]),
		.i_start_rise (tb_start_rise),
		.i_toggle_sel (crb_r[CTL_TOGGLE]),
		.i_force_load (wr_sel[REG_TIMER_B_CTRL] & I_DB[CTL_LOAD]),
		.i_lat_lo_wr  (wr_sel[REG_TIMER_B_LO]),
		.i_lat_hi_wr  (wr_sel[REG_TIMER_B_HI]),
		.i_wdata      (I_DB),
		.o_count      (tb_count),
		.o_underflow  (tb_uf),
		.o_port_out   (tb_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// event status, cleared on read, a new event wins over the clear
	assign evt_set = {3'h0, flag_fall, 1'b0, match_now & ~match_prev_r, tb_uf, ta_uf};

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			evt_r <= REG_RESET;
		end else begin
			evt_r <= (rd_sel[REG_EVENT_STATUS] ? REG_RESET : evt_r) | evt_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// time of day: mains divider and bcd chain
	assign div_last   = cra_r[CTL_RATE_SEL] ? MAINS_PER_TENTH_50 - 3'h1 :
		MAINS_PER_TENTH_60 - 3'h1;
	assign tenth_tick = tod_rise & run_r & (div_r == div_last);
	assign ten_wrap   = tenth_tick & (tenths_r == TENTH_LAST);
	assign sec_wrap   = ten_wrap & (sec_r == SIXTY_LAST);
	assign min_wrap   = sec_wrap & (min_r == SIXTY_LAST);
	assign wr_time    = ~crb_r[CTL_ALARM_SEL];
	assign wr_alarm   = crb_r[CTL_ALARM_SEL];

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			div_r    <= 3'h0;
			run_r    <= 1'b1;
			tenths_r <= 4'h0;
			sec_r    <= 7'h00;
			min_r    <= 7'h00;
			hr_r     <= 5'h00;
			pm_r     <= 1'b0;
		end else begin
			if (tod_rise & run_r) div_r <= (div_r == div_last) ? 3'h0 : div_r + 3'h1;
			if (wr_sel[REG_CLOCK_HOURS] & wr_time) run_r <= 1'b0;
			else if (wr_sel[REG_CLOCK_TENTHS] & wr_time) run_r <= 1'b1;
			if (wr_sel[REG_CLOCK_TENTHS] & wr_time) begin
				tenths_r <= I_DB[3:0];
				div_r    <= 3'h0;
			end else if (tenth_tick) begin
				tenths_r <= ten_wrap ? 4'h0 : tenths_r + 4'h1;
			end
			if (wr_sel[REG_CLOCK_SECONDS] & wr_time) sec_r <= I_DB[6:0];
			else if (ten_wrap) sec_r <= sec_wrap ? 7'h00 : 7'(bcd_inc({1'b0, sec_r}));
			if (wr_sel[REG_CLOCK_MINUTES] & wr_time) min_r <= I_DB[6:0];
			else if (sec_wrap) min_r <= min_wrap ? 7'h00 : 7'(bcd_inc({1'b0, min_r}));
			if (wr_sel[REG_CLOCK_HOURS] & wr_time) begin
				hr_r <= I_DB[4:0];
				pm_r <= I_DB[AFTERNOON_BIT];
			end else if (min_wrap) begin
				if (hr_r == HOUR_TWELVE) begin
					hr_r <= HOUR_ONE;
				end else if (hr_r == HOUR_ELEVEN) begin
					hr_r <= HOUR_TWELVE;
					pm_r <= ~pm_r;
				end else begin
					hr_r <= 5'(bcd_inc({3'h0, hr_r}));
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alarm registers and match detect
	assign match_now = {alm_pm_r, alm_hr_r, alm_min_r, alm_sec_r, alm_tenths_r} ==
		{pm_r, hr_r, min_r, sec_r, tenths_r};

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			alm_tenths_r <= 4'h0;
			alm_sec_r    <= 7'h00;
			alm_min_r    <= 7'h00;
			alm_hr_r     <= 5'h00;
			alm_pm_r     <= 1'b0;
			match_prev_r <= 1'b1;
		end else begin
			match_prev_r <= match_now;
			if (wr_sel[REG_CLOCK_TENTHS] & wr_alarm) alm_tenths_r <= I_DB[3:0];
			if (wr_sel[REG_CLOCK_SECONDS] & wr_alarm) alm_sec_r <= I_DB[6:0];
			if (wr_sel[REG_CLOCK_MINUTES] & wr_alarm) alm_min_r <= I_DB[6:0];
			if (wr_sel[REG_CLOCK_HOURS] & wr_alarm) begin
				alm_hr_r <= I_DB[4:0];
				alm_pm_r <= I_DB[AFTERNOON_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read freeze of the time registers
	assign live_word[0] = {4'h0, tenths_r};
	assign live_word[1] = {1'b0, sec_r};
	assign live_word[2] = {1'b0, min_r};
	assign live_word[3] = {pm_r, 2'h0, hr_r};

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			frozen_r <= 1'b0;
			for (int i = 0; i < 4; i++) snap_r[i] <= REG_RESET;
		end else begin
			if (rd_sel[REG_CLOCK_HOURS]) frozen_r <= 1'b1;
			else if (rd_sel[REG_CLOCK_TENTHS]) frozen_r <= 1'b0;
			if (rd_sel[REG_CLOCK_HOURS] & ~frozen_r) begin
				for (int i = 0; i < 4; i++) snap_r[i] <= live_word[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data selection
	assign rd_word[REG_PORT_A_DATA]   = pa_sync_r;
	assign rd_word[REG_PORT_B_DATA]   = pb_sync_r;
	assign rd_word[REG_PORT_A_DIR]    = port_a_direction_r;
	assign rd_word[REG_PORT_B_DIR]    = port_b_direction_r;
	assign rd_word[REG_TIMER_A_LO]    = ta_count[7:0];
	assign rd_word[REG_TIMER_A_HI]    = ta_count[15:8];
	assign rd_word[REG_TIMER_B_LO]    = tb_count[7:0];
	assign rd_word[REG_TIMER_B_HI]    = tb_count[15:8];
	assign rd_word[REG_CLOCK_TENTHS]  = frozen_r ? snap_r[0] : live_word[0];
	assign rd_word[REG_CLOCK_SECONDS] = frozen_r ? snap_r[1] : live_word[1];
	assign rd_word[REG_CLOCK_MINUTES] = frozen_r ? snap_r[2] : live_word[2];
	assign rd_word[REG_CLOCK_HOURS]   = frozen_r ? snap_r[3] : live_word[3];
	assign rd_word[4'hc]              = REG_RESET;
	assign rd_word[REG_EVENT_STATUS]  = evt_r;
	assign rd_word[REG_TIMER_A_CTRL]  = cra_r;
	assign rd_word[REG_TIMER_B_CTRL]  = crb_r;
endmodule

// >>> hw/ptu_pkg.sv
package ptu_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [3:0] REG_PORT_A_DATA   = 4'h0;
	localparam logic [3:0] REG_PORT_B_DATA   = 4'h1;
	localparam logic [3:0] REG_PORT_A_DIR    = 4'h2;
	localparam logic [3:0] REG_PORT_B_DIR    = 4'h3;
	localparam logic [3:0] REG_TIMER_A_LO    = 4'h4;
	localparam logic [3:0] REG_TIMER_A_HI    = 4'h5;
	localparam logic [3:0] REG_TIMER_B_LO    = 4'h6;
	localparam logic [3:0] REG_TIMER_B_HI    = 4'h7;
	localparam logic [3:0] REG_CLOCK_TENTHS  = 4'h8;
	localparam logic [3:0] REG_CLOCK_SECONDS = 4'h9;
	localparam logic [3:0] REG_CLOCK_MINUTES = 4'ha;
	localparam logic [3:0] REG_CLOCK_HOURS   = 4'hb;
	localparam logic [3:0] REG_EVENT_STATUS  = 4'hd;
	localparam logic [3:0] REG_TIMER_A_CTRL  = 4'he;
	localparam logic [3:0] REG_TIMER_B_CTRL  = 4'hf;
	localparam int         REG_COUNT         = 16;
	////////////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int CTL_START      = 0;
	localparam int CTL_PORT_EN    = 1;
	localparam int CTL_TOGGLE     = 2;
	localparam int CTL_ONE_SHOT   = 3;
	localparam int CTL_LOAD       = 4;
	localparam int CTL_INMODE     = 5;
	localparam int CTL_INMODE_HI  = 6;
	localparam int CTL_RATE_SEL   = 7;
	localparam int CTL_ALARM_SEL  = 7;
	localparam logic [1:0] SRC_SYS_CLOCK  = 2'h0;
	localparam logic [1:0] SRC_COUNT_PIN  = 2'h1;
	localparam logic [1:0] SRC_A_UNDER    = 2'h2;
	localparam logic [1:0] SRC_A_UNDER_HI = 2'h3;
	////////////////////////////////////////////////////////////////////////////////
	// event status bits
	localparam int EVT_TIMER_A = 0;
	localparam int EVT_TIMER_B = 1;
	localparam int EVT_ALARM   = 2;
	localparam int EVT_FLAG    = 4;
	////////////////////////////////////////////////////////////////////////////////
	// reset values, pin positions, clock constants
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [15:0] LATCH_RESET      = 16'hffff;
	localparam int          PB_TIMER_A_BIT   = 6;
	localparam int          PB_TIMER_B_BIT   = 7;
	localparam int          AFTERNOON_BIT    = 7;
	localparam logic [2:0]  MAINS_PER_TENTH_60 = 3'h6;
	localparam logic [2:0]  MAINS_PER_TENTH_50 = 3'h5;
	localparam logic [3:0]  TENTH_LAST       = 4'h9;
	localparam logic [6:0]  SIXTY_LAST       = 7'h59;
	localparam logic [4:0]  HOUR_ONE         = 5'h01;
	localparam logic [4:0]  HOUR_ELEVEN      = 5'h11;
	localparam logic [4:0]  HOUR_TWELVE      = 5'h12;
endpackage

// >>> hw/ptu_pin_sync.sv
module ptu_pin_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// two-stage sync plus edge detect on the second stage
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_level = sync_r;
	assign o_rise  = sync_r & ~prev_r;
	assign o_fall  = ~sync_r & prev_r;
endmodule

// >>> hw/ptu_timer.sv
module ptu_timer
	import ptu_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_count_en,
	input  wire logic       i_start,
	input  wire logic       i_start_rise,
	input  wire logic       i_toggle_sel,
	input  wire logic       i_force_load,
	input  wire logic       i_lat_lo_wr,
	input  wire logic       i_lat_hi_wr,
	input  wire logic [7:0] i_wdata,
	output logic [15:0]     o_count,
	output logic            o_underflow,
	output logic            o_port_out
);
	logic [15:0] latch_r;
	logic [15:0] latch_nxt;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        uf_r;
	logic        uf_nxt;
	logic        tog_r;
	logic        tog_nxt;
	logic        counting;

	////////////////////////////////////////////////////////////////////////////////
	// latch and counter next values
	assign counting  = i_start & i_count_en;
	assign uf_nxt    = counting & (count_r == '0) & ~i_force_load;
	assign latch_nxt = i_lat_hi_wr ? {i_wdata, latch_r[7:0]} :
		i_lat_lo_wr ? {latch_r[15:8], i_wdata} : latch_r;
	assign count_nxt = i_force_load ? latch_r :
		(i_lat_hi_wr & ~i_start) ? {i_wdata, latch_r[7:0]} :
		uf_nxt ? latch_r :
		counting ? count_r - 16'h0001 : count_r;
	assign tog_nxt   = i_start_rise ? 1'b1 : uf_nxt ? ~tog_r : tog_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			latch_r <= LATCH_RESET;
			count_r <= LATCH_RESET;
			uf_r    <= 1'b0;
			tog_r   <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			count_r <= count_nxt;
			uf_r    <= uf_nxt;
			tog_r   <= tog_nxt;
		end
	end

	assign o_count     = count_r;
	assign o_underflow = uf_nxt;
	assign o_port_out  = i_toggle_sel ? tog_r : uf_r;
endmodule

// >>> tb/ptu_assertions.sv
module ptu_chk
	import ptu_pkg::*;
(
	input wire logic       I_CLK_SYS,
	input wire logic       I_RST,
	input wire logic       I_CS_N,
	input wire logic       I_RW,
	input wire logic [3:0] I_RS,
	input wire logic [7:0] I_DB,
	input wire logic [7:0] O_DB,
	input wire logic       O_DB_OE,
	input wire logic [7:0] O_PA_OE,
	input wire logic [7:0] O_PB_OE,
	input wire logic       O_HANDSHAKE_STROBE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cs_d_r;
	wire  take   = !I_CS_N && cs_d_r;
	wire  rd_on  = !I_CS_N && I_RW;
	wire  pb_tak = take && I_RS == REG_PORT_B_DATA;
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
		if (I_RST)
			cs_d_r <= 1'b1;
		else
			cs_d_r <= I_CS_N;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	chk_strobe_on_pb:
		assert property (pb_tak |=> !O_HANDSHAKE_STROBE_N) else $error("no strobe");
	chk_strobe_one:
		assert property ($fell(O_HANDSHAKE_STROBE_N) |=> O_HANDSHAKE_STROBE_N) else $error("long");
	chk_strobe_cause:
		assert property ($fell(O_HANDSHAKE_STROBE_N) |-> $past(pb_tak)) else $error("stray");
	chk_read_enable:
		assert property (O_DB_OE == $past(rd_on)) else $error("read enable");
	chk_dir_a_write:
		assert property (take && !I_RW && I_RS == REG_PORT_A_DIR |-> ##2 O_PA_OE == $past(I_DB, 2))
			else $error("direction write");
	chk_dir_a_read:
		assert property (take && I_RW && I_RS == REG_PORT_A_DIR |=> O_DB == O_PA_OE)
			else $error("direction read");
	chk_timer_pin:
		assert property (take && !I_RW && I_RS == REG_TIMER_A_CTRL && I_DB[CTL_PORT_EN]
			|-> ##[1:3] O_PB_OE[PB_TIMER_A_BIT]) else $error("timer pin");
	chk_reset_quiet:
		assert property ($fell(I_RST) |-> !O_DB_OE && O_PA_OE == 8'h00 && O_PB_OE == 8'h00
			&& O_HANDSHAKE_STROBE_N) else $error("reset state");
endmodule

// >>> tb/ptu_cpu_model.sv
module ptu_cpu_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_db,
	output logic            o_cs_n,
	output logic            o_rw,
	output logic [3:0]      o_rs,
	output logic [7:0]      o_db
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_cs_n = 1'b1;
		o_rw   = 1'b1;
		o_rs   = 4'h0;
		o_db   = 8'h00;
	end
	task automatic acc(input logic rw, input logic [3:0] rs, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		o_rw   <= rw;
		o_rs   <= rs;
		o_db   <= rw ? ~o_db : wd;
		repeat (2) @(posedge i_clk);
		rd = i_db;
		o_cs_n <= 1'b1;
		o_db   <= ~o_db;
	endtask
endmodule

// >>> tb/testbench.sv
module testbench import ptu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, rst = 1'b1, flag_n = 1'b1, time_of_day_clock = 1'b0, cnt = 1'b0;
	logic       cs_n, rw, db_oe, strobe_n;
	logic [3:0] rs;
	logic [7:0] pa = 8'hff, pb = 8'hff, db, o_db, o_pa, o_pa_oe, o_pb, o_pb_oe;
	int         err_count = 0, n_tests = 0, n_low = 0, n_hi = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (strobe_n === 1'b0) n_low++;
	always @(posedge clk) if (o_pb[7] === 1'b1) n_hi++;
	ptu_top u_ptu_top (.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n), .I_RW(rw), .I_RS(rs),
		.I_DB(db), .O_DB(o_db), .O_DB_OE(db_oe), .I_PA(pa), .O_PA(o_pa), .O_PA_OE(o_pa_oe),
		.I_PB(pb), .O_PB(o_pb), .O_PB_OE(o_pb_oe), .O_HANDSHAKE_STROBE_N(strobe_n),
		.I_FLAG_N(flag_n), .I_COUNT_PIN(cnt), .I_TOD_PIN(time_of_day_clock));
	ptu_cpu_model u_ptu_cpu_model (.i_clk(clk), .i_db(o_db), .o_cs_n(cs_n), .o_rw(rw),
		.o_rs(rs), .o_db(db));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		logic [7:0] d;
		u_ptu_cpu_model.acc(1'b0, a, v, d);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_ptu_cpu_model.acc(1'b1, a, 8'h00, d);
		chk(d, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic mains(input int n);
		repeat (n) begin
			@(posedge clk) time_of_day_clock <= 1'b1;
			tick(3);
			time_of_day_clock <= 1'b0;
			tick(3);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset();
		logic [7:0] d;
		u_ptu_cpu_model.acc(1'b1, REG_EVENT_STATUS, 8'h00, d);
		rc(REG_PORT_A_DIR, 8'h00);
		rc(REG_TIMER_B_HI, 8'hff);
		rc(REG_TIMER_A_CTRL, 8'h00);
		rc(REG_PORT_A_DATA, 8'hff);
	endtask
	task automatic t_ports();
		int s;
		@(posedge clk) pa <= 8'h3c;
		wr(REG_PORT_A_DIR, 8'h0f);
		wr(REG_PORT_A_DATA, 8'ha5);
		tick(1);
		chk(o_pa_oe, 8'h0f);
		chk(o_pa[3:0], 4'h5);
		s = n_low;
		rc(REG_PORT_A_DATA, 8'h3c);
		wr(REG_PORT_B_DATA, 8'h12);
		rc(REG_PORT_B_DATA, 8'hff);
		tick(2);
		chk(16'(n_low - s), 16'h0002);
	endtask
	task automatic t_flag();
		@(posedge clk) flag_n <= 1'b0;
		tick(5);
		rc(REG_EVENT_STATUS, 8'h10);
		rc(REG_EVENT_STATUS, 8'h00);
		flag_n <= 1'b1;
		tick(5);
		rc(REG_EVENT_STATUS, 8'h00);
	endtask
	task automatic t_timer();
		logic [7:0] v;
		wr(REG_TIMER_A_LO, 8'h03);
		wr(REG_TIMER_A_HI, 8'h00);
		rc(REG_TIMER_A_LO, 8'h03);
		wr(REG_TIMER_A_CTRL, 8'h09);
		tick(10);
		rc(REG_TIMER_A_LO, 8'h03);
		rc(REG_TIMER_A_CTRL, 8'h08);
		rc(REG_EVENT_STATUS, 8'h01);
		wr(REG_TIMER_A_LO, 8'h40);
		wr(REG_TIMER_A_HI, 8'h00);
		wr(REG_TIMER_A_CTRL, 8'h07);
		tick(2);
		chk(o_pb_oe[6], 1'b1);
		chk(o_pb[6], 1'b1);
		tick(70);
		chk(o_pb[6], 1'b0);
		rc(REG_EVENT_STATUS, 8'h01);
		wr(REG_TIMER_A_HI, 8'h01);
		rc(REG_TIMER_A_HI, 8'h00);
		rc(REG_TIMER_A_CTRL, 8'h07);
		wr(REG_TIMER_A_CTRL, 8'h00);
		u_ptu_cpu_model.acc(1'b1, REG_TIMER_A_LO, 8'h00, v);
		tick(5);
		rc(REG_TIMER_A_LO, v);
		wr(REG_TIMER_A_CTRL, 8'h10);
		rc(REG_TIMER_A_HI, 8'h01);
		rc(REG_TIMER_A_CTRL, 8'h00);
	endtask
	task automatic t_count();
		wr(REG_TIMER_B_LO, 8'h02);
		wr(REG_TIMER_B_HI, 8'h00);
		wr(REG_TIMER_A_CTRL, 8'h21);
		wr(REG_TIMER_B_CTRL, 8'h23);
		repeat (3) begin
			@(posedge clk) cnt <= 1'b1;
			tick(3);
			cnt <= 1'b0;
			tick(3);
		end
		chk(o_pb_oe[7], 1'b1);
		chk(16'(n_hi), 16'h0001);
		rc(REG_TIMER_A_LO, 8'h3d);
		rc(REG_TIMER_B_LO, 8'h02);
		rc(REG_EVENT_STATUS, 8'h02);
		wr(REG_TIMER_A_LO, 8'h01);
		wr(REG_TIMER_A_HI, 8'h00);
		wr(REG_TIMER_A_CTRL, 8'h11);
		wr(REG_TIMER_B_CTRL, 8'h51);
		tick(10);
		rc(REG_EVENT_STATUS, 8'h03);
		wr(REG_TIMER_B_CTRL, 8'h71);
		tick(10);
		rc(REG_TIMER_B_LO, 8'h02);
		wr(REG_TIMER_A_CTRL, 8'h00);
		wr(REG_TIMER_B_CTRL, 8'h00);
	endtask
	task automatic t_tod();
		logic [7:0] d;
		wr(REG_CLOCK_HOURS, 8'h11);
		wr(REG_CLOCK_MINUTES, 8'h59);
		wr(REG_CLOCK_SECONDS, 8'h59);
		wr(REG_CLOCK_TENTHS, 8'h09);
		mains(6);
		rc(REG_CLOCK_HOURS, 8'h92);
		rc(REG_CLOCK_MINUTES, 8'h00);
		wr(REG_TIMER_A_CTRL, 8'h80);
		mains(5);
		rc(REG_CLOCK_TENTHS, 8'h00);
		rc(REG_CLOCK_TENTHS, 8'h01);
		wr(REG_CLOCK_HOURS, 8'h01);
		mains(5);
		rc(REG_CLOCK_TENTHS, 8'h01);
		u_ptu_cpu_model.acc(1'b1, REG_EVENT_STATUS, 8'h00, d);
		wr(REG_TIMER_B_CTRL, 8'h80);
		wr(REG_CLOCK_TENTHS, 8'h02);
		wr(REG_CLOCK_HOURS, 8'h01);
		rc(REG_CLOCK_TENTHS, 8'h01);
		wr(REG_TIMER_B_CTRL, 8'h00);
		wr(REG_CLOCK_TENTHS, 8'h01);
		mains(5);
		rc(REG_EVENT_STATUS, 8'h04);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_ports();
		t_flag();
		t_timer();
		t_count();
		t_tod();
		finish_test();
	end
	initial begin
		#50000;
		err_count++;
		finish_test();
	end
endmodule
bind ptu_top ptu_chk u_ptu_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CS_N(I_CS_N),
	.I_RW(I_RW), .I_RS(I_RS), .I_DB(I_DB), .O_DB(O_DB), .O_DB_OE(O_DB_OE),
	.O_PA_OE(O_PA_OE), .O_PB_OE(O_PB_OE), .O_HANDSHAKE_STROBE_N(O_HANDSHAKE_STROBE_N));
